// ===== hw/clock_control_defines.vh
// Register map, field positions, reset values and timing counts of the clock control block
`ifndef CLOCK_CONTROL_DEFINES_VH
`define CLOCK_CONTROL_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_SYSTEM_CLOCK_CONTROL 4'h0
`define OFS_INTERNAL_FAST_OSC_CONTROL 4'h4
`define OFS_EXTERNAL_FAST_CRYSTAL_CONTROL 4'h8
`define OFS_EXTERNAL_SLOW_CRYSTAL_CONTROL 4'hC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_SYS_CLOCK_SELECT_LO 5
`define POS_SYS_CLOCK_SELECT_HI 7
`define POS_FAST_SOURCE_SELECT 3
`define POS_SLOW_SOURCE_SELECT 2
`define POS_FAST_IDLE_ENABLE 1
`define POS_SLOW_IDLE_ENABLE 0
`define POS_FAST_FREQ_LO 2
`define POS_FAST_FREQ_HI 3
`define POS_STABLE 1
`define POS_ENABLE 0
`define POS_FAST_CRYSTAL_RANGE 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SYS_CLOCK_SELECT 3'h0
`define RST_SOURCE_BIT 1'h0
`define RST_IDLE_BIT 1'h0
`define RST_FAST_FREQ 2'h0
`define RST_INTERNAL_FAST_ENABLE 1'h1
`define RST_CRYSTAL_ENABLE 1'h0
`define RST_CRYSTAL_RANGE 1'h0

// ----------------------------------------
// Clock select codes and power modes
// ----------------------------------------
`define SEL_SUB_CLOCK 3'h7
`define MODE_FAST 3'h0
`define MODE_SLOW 3'h1
`define MODE_SLEEP 3'h2
`define MODE_IDLE_SLOW_ONLY 3'h3
`define MODE_IDLE_BOTH_CLOCKS 3'h4
`define MODE_IDLE_FAST_ONLY 3'h5

// ----------------------------------------
// Stabilisation counts in oscillator ticks
// ----------------------------------------
`define STABLE_TICKS_INTERNAL_FAST 16'h0010
`define STABLE_TICKS_FAST_CRYSTAL 16'h0400
`define STABLE_TICKS_SLOW_CRYSTAL 16'h0100

`endif

// ===== hw/system_clock_source_control.v
// Clock source, divider, oscillator enable and halt mode control with Wishbone registers
//
// Behaviour
// - Select field picks high-speed clock undivided, divided 2..64, or sub clock.
// - Unimplemented register bits read zero and ignore writes.
// - Fast source bit: 0 internal RC, 1 external crystal onto high-speed clock.
// - Slow source bit: 0 internal slow RC, 1 slow crystal onto sub clock.
// - In halt, high-speed oscillator runs only if fast idle enable is set.
// - In halt, low-speed oscillator runs only if slow idle enable is set.
// - Internal slow RC stays on while the watchdog is enabled.
// - Internal fast frequency code: 00 4MHz, 01 8MHz, 10 12MHz, 11 4MHz.
// - Internal fast stable flag reads 0 after enable, 1 once stable.
// - Internal fast enable turns oscillator on or off; resets to 1.
// - Crystal range bit: 0 up to 10MHz, 1 above 10MHz.
// - Fast crystal stable flag reads 0 after enable, 1 once stable.
// - Fast crystal enable turns it on or off; resets to 0.
// - Slow crystal stable flag reads 0 after enable, 1 once stable.
// - Slow crystal enable turns it on or off; resets to 0.
// - Halt chooses sleep or an idle mode from both idle enable bits.
// - Switch to sub clock completes only once selected slow oscillator is stable.
// - Idle bits fast/slow: 00 sleep, 01 slow only, 11 both, 10 fast only.
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`include "clock_control_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module system_clock_source_control (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire internal_fast_osc_tick_i,
  input wire external_fast_crystal_tick_i,
  input wire internal_slow_osc_tick_i,
  input wire external_slow_crystal_tick_i,
  input wire watchdog_enable_i,
  input wire halt_i,
  input wire wake_i,
  output reg internal_fast_osc_run_o,
  output reg external_fast_crystal_run_o,
  output reg internal_slow_osc_run_o,
  output reg external_slow_crystal_run_o,
  output reg [1:0] internal_fast_freq_o,
  output reg fast_crystal_range_o,
  output reg high_speed_clock_tick_o,
  output reg sub_clock_tick_o,
  output reg sys_clock_tick_o,
  output reg [2:0] active_clock_select_o,
  output reg [2:0] power_mode_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [5:0] div_mask;
    input [2:0] code;
    begin
      div_mask = (6'h01 << code) - 6'h01;
    end
  endfunction

  function [15:0] stab_count;
    input run;
    input tick;
    input [15:0] cnt;
    input [15:0] limit;
    begin
      if (!run) begin
        stab_count = 16'h0000;
      end else if (tick && cnt != limit) begin
        stab_count = cnt + 16'h0001;
      end else begin
        stab_count = cnt;
      end
    end
  endfunction

  function [2:0] run_mode;
    input [2:0] sel;
    begin
      if (sel == `SEL_SUB_CLOCK) begin
        run_mode = `MODE_SLOW;
      end else begin
        run_mode = `MODE_FAST;
      end
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [2:0] sys_clock_select;
  reg fast_source_select;
  reg slow_source_select;
  reg fast_idle_enable;
  reg slow_idle_enable;
  reg [1:0] internal_fast_freq_select;
  reg internal_fast_enable;
  reg fast_crystal_range;
  reg fast_crystal_enable;
  reg slow_crystal_enable;
  reg [15:0] internal_fast_cnt;
  reg [15:0] fast_crystal_cnt;
  reg [15:0] slow_crystal_cnt;
  reg halted;
  reg [2:0] active_sel;
  reg active_fast_src;
  reg active_slow_src;
  reg [5:0] div_cnt;

  wire internal_fast_stable;
  wire fast_crystal_stable;
  wire slow_crystal_stable;
  wire bus_req;
  wire bus_wr;
  wire [7:0] system_clock_control;
  wire [7:0] internal_fast_osc_control;
  wire [7:0] external_fast_crystal_control;
  wire [7:0] external_slow_crystal_control;

  reg fast_run;
  reg slow_run;
  reg internal_slow_osc_run;
  reg hs_tick;
  reg sub_tick;
  reg sys_tick;
  reg src_running;
  reg slow_ready;
  reg [2:0] next_mode;

  assign internal_fast_stable = internal_fast_cnt == `STABLE_TICKS_INTERNAL_FAST;
  assign fast_crystal_stable = fast_crystal_cnt == `STABLE_TICKS_FAST_CRYSTAL;
  assign slow_crystal_stable = slow_crystal_cnt == `STABLE_TICKS_SLOW_CRYSTAL;

  // ----------------------------------------
  // Register read images
  // ----------------------------------------
  assign system_clock_control = {sys_clock_select, 1'b0, fast_source_select, slow_source_select,
                                 fast_idle_enable, slow_idle_enable};
  assign internal_fast_osc_control = {4'h0, internal_fast_freq_select, internal_fast_stable,
                                      internal_fast_enable};
  assign external_fast_crystal_control = {5'h00, fast_crystal_range, fast_crystal_stable,
                                          fast_crystal_enable};
  assign external_slow_crystal_control = {6'h00, slow_crystal_stable, slow_crystal_enable};

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

  // ----------------------------------------
  // Oscillator run control
  // ----------------------------------------
  always @* begin
    fast_run = !halted || fast_idle_enable;
    slow_run = !halted || slow_idle_enable;
    internal_fast_osc_run_o = internal_fast_enable && fast_run;
    external_fast_crystal_run_o = fast_crystal_enable && fast_run;
    external_slow_crystal_run_o = slow_crystal_enable && slow_run;
    internal_slow_osc_run = slow_run && !slow_source_select;
    internal_slow_osc_run_o = internal_slow_osc_run || watchdog_enable_i;
  end

  // ----------------------------------------
  // Clock tick routing
  // ----------------------------------------
  always @* begin
    if (active_fast_src) begin
      hs_tick = external_fast_crystal_tick_i && external_fast_crystal_run_o;
    end else begin
      hs_tick = internal_fast_osc_tick_i && internal_fast_osc_run_o;
    end
    if (active_slow_src) begin
      sub_tick = external_slow_crystal_tick_i && external_slow_crystal_run_o;
    end else begin
      sub_tick = internal_slow_osc_tick_i && internal_slow_osc_run;
    end
    if (halted) begin
      sys_tick = 1'b0;
    end else if (active_sel == `SEL_SUB_CLOCK) begin
      sys_tick = sub_tick;
    end else begin
      sys_tick = hs_tick && (div_cnt == div_mask(active_sel));
    end
  end

  // ----------------------------------------
  // Source switch readiness
  // ----------------------------------------
  always @* begin
    if (active_sel == `SEL_SUB_CLOCK) begin
      src_running = active_slow_src ? external_slow_crystal_run_o : internal_slow_osc_run;
    end else begin
      src_running = active_fast_src ? external_fast_crystal_run_o : internal_fast_osc_run_o;
    end
    slow_ready = !slow_source_select || slow_crystal_stable;
  end

  // ----------------------------------------
  // Halt mode decode
  // ----------------------------------------
  always @* begin
    case ({fast_idle_enable, slow_idle_enable})
      2'b00: next_mode = `MODE_SLEEP;
      2'b01: next_mode = `MODE_IDLE_SLOW_ONLY;
      2'b11: next_mode = `MODE_IDLE_BOTH_CLOCKS;
      default: next_mode = `MODE_IDLE_FAST_ONLY;
    endcase
  end

  // ----------------------------------------
  // Wishbone acknowledge
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // ----------------------------------------
  // Wishbone read data
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= 32'h00000000;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          `OFS_SYSTEM_CLOCK_CONTROL: wb_dat_o <= {24'h000000, system_clock_control};
          `OFS_INTERNAL_FAST_OSC_CONTROL: wb_dat_o <= {24'h000000, internal_fast_osc_control};
          `OFS_EXTERNAL_FAST_CRYSTAL_CONTROL: wb_dat_o <= {24'h000000, external_fast_crystal_control};
          `OFS_EXTERNAL_SLOW_CRYSTAL_CONTROL: wb_dat_o <= {24'h000000, external_slow_crystal_control};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Control register writes
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sys_clock_select <= `RST_SYS_CLOCK_SELECT;
      fast_source_select <= `RST_SOURCE_BIT;
      slow_source_select <= `RST_SOURCE_BIT;
      fast_idle_enable <= `RST_IDLE_BIT;
      slow_idle_enable <= `RST_IDLE_BIT;
      internal_fast_freq_select <= `RST_FAST_FREQ;
      internal_fast_enable <= `RST_INTERNAL_FAST_ENABLE;
      fast_crystal_range <= `RST_CRYSTAL_RANGE;
      fast_crystal_enable <= `RST_CRYSTAL_ENABLE;
      slow_crystal_enable <= `RST_CRYSTAL_ENABLE;
    end else if (bus_wr) begin
      case (wb_adr_i)
        `OFS_SYSTEM_CLOCK_CONTROL: begin
          sys_clock_select <= wb_dat_i[`POS_SYS_CLOCK_SELECT_HI:`POS_SYS_CLOCK_SELECT_LO];
          fast_source_select <= wb_dat_i[`POS_FAST_SOURCE_SELECT];
          slow_source_select <= wb_dat_i[`POS_SLOW_SOURCE_SELECT];
          fast_idle_enable <= wb_dat_i[`POS_FAST_IDLE_ENABLE];
          slow_idle_enable <= wb_dat_i[`POS_SLOW_IDLE_ENABLE];
        end
        `OFS_INTERNAL_FAST_OSC_CONTROL: begin
          internal_fast_freq_select <= wb_dat_i[`POS_FAST_FREQ_HI:`POS_FAST_FREQ_LO];
          internal_fast_enable <= wb_dat_i[`POS_ENABLE];
        end
        `OFS_EXTERNAL_FAST_CRYSTAL_CONTROL: begin
          if (!fast_crystal_enable) begin
            fast_crystal_range <= wb_dat_i[`POS_FAST_CRYSTAL_RANGE];
          end
          fast_crystal_enable <= wb_dat_i[`POS_ENABLE];
        end
        `OFS_EXTERNAL_SLOW_CRYSTAL_CONTROL: begin
          slow_crystal_enable <= wb_dat_i[`POS_ENABLE];
        end
        default: begin
          sys_clock_select <= sys_clock_select;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Stabilisation counters
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      internal_fast_cnt <= 16'h0000;
      fast_crystal_cnt <= 16'h0000;
      slow_crystal_cnt <= 16'h0000;
    end else begin
      internal_fast_cnt <= stab_count(internal_fast_osc_run_o, internal_fast_osc_tick_i,
                                      internal_fast_cnt, `STABLE_TICKS_INTERNAL_FAST);
      fast_crystal_cnt <= stab_count(external_fast_crystal_run_o, external_fast_crystal_tick_i,
                                     fast_crystal_cnt, `STABLE_TICKS_FAST_CRYSTAL);
      slow_crystal_cnt <= stab_count(external_slow_crystal_run_o, external_slow_crystal_tick_i,
                                     slow_crystal_cnt, `STABLE_TICKS_SLOW_CRYSTAL);
    end
  end

  // ----------------------------------------
  // Glitch-free source and divider switching
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      active_sel <= `RST_SYS_CLOCK_SELECT;
      active_fast_src <= `RST_SOURCE_BIT;
      active_slow_src <= `RST_SOURCE_BIT;
      div_cnt <= 6'h00;
    end else begin
      if (hs_tick) begin
        div_cnt <= (div_cnt == div_mask(active_sel)) ? 6'h00 : div_cnt + 6'h01;
      end
      if (sys_tick || !src_running) begin
        if (sys_clock_select != `SEL_SUB_CLOCK || slow_ready) begin
          active_sel <= sys_clock_select;
          div_cnt <= 6'h00;
        end
        active_fast_src <= fast_source_select;
        active_slow_src <= slow_source_select;
      end
    end
  end

  // ----------------------------------------
  // Halt and wake
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      halted <= 1'b0;
      power_mode_o <= `MODE_FAST;
    end else if (halted) begin
      if (wake_i) begin
        halted <= 1'b0;
        power_mode_o <= run_mode(active_sel);
      end
    end else if (halt_i) begin
      halted <= 1'b1;
      power_mode_o <= next_mode;
    end else begin
      power_mode_o <= run_mode(active_sel);
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      internal_fast_freq_o <= `RST_FAST_FREQ;
      fast_crystal_range_o <= `RST_CRYSTAL_RANGE;
      high_speed_clock_tick_o <= 1'b0;
      sub_clock_tick_o <= 1'b0;
      sys_clock_tick_o <= 1'b0;
      active_clock_select_o <= `RST_SYS_CLOCK_SELECT;
    end else begin
      internal_fast_freq_o <= (internal_fast_freq_select == 2'h3) ? 2'h0 : internal_fast_freq_select;
      fast_crystal_range_o <= fast_crystal_range;
      high_speed_clock_tick_o <= hs_tick;
      sub_clock_tick_o <= sub_tick;
      sys_clock_tick_o <= sys_tick;
      active_clock_select_o <= active_sel;
    end
  end

endmodule

`default_nettype wire

// ===== testbench/system_clock_source_control_monitor.sv
// Concurrent checks on the clock control block ports
`timescale 1ns/1ps
`default_nettype none
module clock_control_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic watchdog_enable_i,
  input wire logic halt_i,
  input wire logic wake_i,
  input wire logic internal_fast_osc_run_o,
  input wire logic external_fast_crystal_run_o,
  input wire logic internal_slow_osc_run_o,
  input wire logic [1:0] internal_fast_freq_o,
  input wire logic fast_crystal_range_o,
  input wire logic high_speed_clock_tick_o,
  input wire logic sub_clock_tick_o,
  input wire logic sys_clock_tick_o,
  input wire logic [2:0] active_clock_select_o,
  input wire logic [2:0] power_mode_o
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reset_osc: assert property ($past(rst_i) |-> internal_fast_osc_run_o && !external_fast_crystal_run_o)
    else $error("oscillator power wrong after reset");
  a_watchdog_keeps: assert property (watchdog_enable_i |-> internal_slow_osc_run_o)
    else $error("slow RC off while watchdog enabled");
  a_halt_enters: assert property (halt_i && power_mode_o < 3'h2 |=> power_mode_o >= 3'h2)
    else $error("halt did not stop the CPU");
  a_wake_leaves: assert property (wake_i && power_mode_o >= 3'h2 |=> power_mode_o < 3'h2)
    else $error("wake did not resume");
  a_halt_no_sys: assert property (power_mode_o >= 3'h2 && $past(power_mode_o) >= 3'h2 |-> !sys_clock_tick_o)
    else $error("system tick while halted");
  a_sys_undivided: assert property (active_clock_select_o == 3'h0 && $stable(active_clock_select_o)
    && power_mode_o == 3'h0 && $stable(power_mode_o) |-> sys_clock_tick_o == high_speed_clock_tick_o)
    else $error("undivided system tick differs");
  a_sys_on_sub: assert property (active_clock_select_o == 3'h7 && $stable(active_clock_select_o)
    && power_mode_o == 3'h1 && $stable(power_mode_o) |-> sys_clock_tick_o == sub_clock_tick_o)
    else $error("sub clock system tick differs");
  a_freq_code: assert property (internal_fast_freq_o != 2'h3)
    else $error("unused frequency code shown");
  a_range_frozen: assert property (external_fast_crystal_run_o && $past(external_fast_crystal_run_o, 2)
    && $past(external_fast_crystal_run_o) |-> $stable(fast_crystal_range_o))
    else $error("crystal range changed while running");
  c_halt: cover property (halt_i && power_mode_o < 3'h2);
  c_sub: cover property (active_clock_select_o == 3'h7);
  c_ack: cover property (wb_ack_o);
endmodule
bind system_clock_source_control clock_control_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .watchdog_enable_i(watchdog_enable_i),
  .halt_i(halt_i), .wake_i(wake_i), .internal_fast_osc_run_o(internal_fast_osc_run_o),
  .external_fast_crystal_run_o(external_fast_crystal_run_o), .internal_slow_osc_run_o(internal_slow_osc_run_o),
  .internal_fast_freq_o(internal_fast_freq_o), .fast_crystal_range_o(fast_crystal_range_o),
  .high_speed_clock_tick_o(high_speed_clock_tick_o), .sub_clock_tick_o(sub_clock_tick_o),
  .sys_clock_tick_o(sys_clock_tick_o), .active_clock_select_o(active_clock_select_o),
  .power_mode_o(power_mode_o));
`default_nettype wire

// ===== testbench/system_clock_source_control_tb.sv
// Self-checking testbench for the clock control block
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_control_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, halt = 1'b0, wake = 1'b0, wd = 1'b0;
  logic ton = 1'b0, ack, hs, sub, sys, ifr, fxr, isr, sxr, rng;
  logic [3:0] adr = 4'h0, sel = 4'h0, tk = 4'h0, ptk = 4'h0;
  logic [31:0] dat = 32'h0, dato, rdat;
  logic [1:0] frq;
  logic [2:0] act, pm;
  logic [7:0] rb [4] = '{8'hEF, 8'h0D, 8'h05, 8'h01};
  integer seed = 32'hc520, bad_count = 0, cmp_count = 0, cyc_n = 0, i, j, k, n, c;
  always #20 clk_i = ~clk_i;
  system_clock_source_control DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .internal_fast_osc_tick_i(tk[0]), .external_fast_crystal_tick_i(tk[1]), .internal_slow_osc_tick_i(tk[2]),
    .external_slow_crystal_tick_i(tk[3]), .watchdog_enable_i(wd), .halt_i(halt), .wake_i(wake),
    .internal_fast_osc_run_o(ifr), .external_fast_crystal_run_o(fxr), .internal_slow_osc_run_o(isr),
    .external_slow_crystal_run_o(sxr), .internal_fast_freq_o(frq), .fast_crystal_range_o(rng),
    .high_speed_clock_tick_o(hs), .sub_clock_tick_o(sub), .sys_clock_tick_o(sys),
    .active_clock_select_o(act), .power_mode_o(pm));
  // ----------------------------------------
  // Oscillator ticks, timeout and helpers
  // ----------------------------------------
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    tk <= ton ? 4'($random(seed)) : 4'h0;
    ptk <= tk;
    if (cyc_n == 60000) begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end
  function automatic [2:0] mode(input logic [1:0] b);
    mode = b == 2'h0 ? 3'h2 : b == 2'h1 ? 3'h3 : b == 2'h3 ? 3'h4 : 3'h5;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    c = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1 && ++c < 20);
    chk(32'(ack), 32'h1);
    dato = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(dato, {24'h0, e});
  endtask
  task automatic poll(input logic [3:0] a);
    n = 0;
    do bus(1'b0, a, 8'h00); while (dato[1] !== 1'b1 && ++n < 3000);
  endtask
  task automatic wait_act(input logic [2:0] s);
    n = 0;
    while (act !== s && n < 3000) begin
      @(negedge clk_i);
      n = n + 1;
    end
    chk(32'(act), 32'(s));
  endtask
  task automatic osc(input logic [3:0] a, input logic [7:0] v);
    bus(1'b1, a, v & 8'hFE);
    bus(1'b1, a, v);
    rchk(a, v);
    poll(a);
    rchk(a, v | 8'h02);
    bus(1'b1, a, v & 8'hFE);
    rchk(a, v & 8'hFE);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(32'({ifr, fxr, sxr}), 32'h4);
    for (i = 0; i < 4; i++) begin
      rchk({i[1:0], 2'b00}, i == 1 ? 8'h01 : 8'h00);
      bus(1'b1, {i[1:0], 2'b00}, 8'hFF);
      rchk({i[1:0], 2'b00}, rb[i]);
    end
    bus(1'b1, 4'h2, 8'hFF);
    rchk(4'h2, 8'h00);
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b1, 4'hC, 8'h00);
    bus(1'b1, 4'h8, 8'h00);
    rchk(4'h8, 8'h04);
    chk(32'({fxr, rng}), 32'h1);
    bus(1'b1, 4'h8, 8'h00);
    rchk(4'h8, 8'h00);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 4'h4, {4'h0, i[1:0], 2'b01});
      @(negedge clk_i) chk(32'(frq), i == 3 ? 32'h0 : 32'(i));
    end
    ton = 1'b1;
    osc(4'h4, 8'h01);
    chk(32'(ifr), 32'h0);
    osc(4'h8, 8'h05);
    osc(4'hC, 8'h01);
    bus(1'b1, 4'h4, 8'h01);
    bus(1'b1, 4'h8, 8'h05);
    chk(32'({fxr, rng}), 32'h3);
    bus(1'b1, 4'hC, 8'h01);
    poll(4'h8);
    poll(4'hC);
    for (j = 1; j >= 0; j--) begin
      bus(1'b1, 4'h0, j == 1 ? 8'h0C : 8'h00);
      repeat (200) @(posedge clk_i);
      repeat (64) @(negedge clk_i) chk(32'({hs, sub}), 32'(j ? {ptk[1], ptk[3]} : {ptk[0], ptk[2]}));
    end
    for (i = 0; i < 7; i++) begin
      bus(1'b1, 4'h0, {i[2:0], 5'h00});
      wait_act(i[2:0]);
      c = 0;
      n = 0;
      k = 0;
      while (c < 2 && n < 3000) begin
        @(negedge clk_i);
        n = n + 1;
        if (c == 1 && hs === 1'b1) k = k + 1;
        if (sys === 1'b1) c = c + 1;
      end
      chk(k, 1 << i);
    end
    bus(1'b1, 4'hC, 8'h00);
    bus(1'b1, 4'h0, 8'hE4);
    repeat (100) @(posedge clk_i);
    chk(32'(act), 32'h6);
    bus(1'b1, 4'hC, 8'h01);
    wait_act(3'h7);
    chk(32'(pm), 32'h1);
    bus(1'b1, 4'h4, 8'h00);
    bus(1'b1, 4'h4, 8'h01);
    poll(4'h4);
    rchk(4'h4, 8'h03);
    bus(1'b1, 4'h0, 8'h00);
    wait_act(3'h0);
    for (i = 0; i < 4; i++) begin
      @(posedge clk_i) wd <= 1'($random(seed));
      bus(1'b1, 4'h0, {6'h00, i[1:0]});
      halt <= 1'b1;
      @(posedge clk_i);
      halt <= 1'b0;
      @(negedge clk_i);
      chk(32'(pm), 32'(mode(i[1:0])));
      chk(32'({ifr, isr}), 32'({i[1], i[0] | wd}));
      @(posedge clk_i);
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      @(negedge clk_i);
      chk(32'(pm), 32'h0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
